// file: design/cpu_power_state_throttle.sv
// Per-processor clock throttle and idle entry logic behind an APB slave
//
// Overview of operation
// - While enabled, processor runs at least at the programmed duty fraction.
// - Run share is duty over two to the width, never below it.
// - Duty field position and width are configuration constants.
// - Throttle by periodic low clock-stop request; high share emulates division.
// - Reading level-two entry register enters C2 precisely on that read.
// - Reading level-three entry register enters C3 precisely on that read.
// - In C2 caches stay coherent; snooping keeps running.
// - One separate control block instance per processor.
// - At least one low-power state besides C0 is offered.
// - C1 is entered by halt instruction only, no logic here.
// - C0 executes full or throttled; other states execute nothing.
// - C3 without arbiter disable needs flush-and-invalidate support.
// - S2 or S3 support needs a platform cache flush means.
// - Flush-only platforms advertise flush-only and clear full flag.
// - Manual flush: read of at most 2 Mbytes flushes caches.
// - Interrupt or reset returns the complex from C2 to running.
// - Bus master wake enable set lets bus requests end idle.
//
// The APB slave port and the register offsets are this design's own decisions.
`include "cpu_throttle_cfg.svh"

module cpu_power_state_throttle (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire cpu_throttle_pkg::apb_req_s apbReq,
  output cpu_throttle_pkg::apb_rsp_s apbRsp,
  // Wake sources from outside the clock domain
  input wire logic irqPin,
  input wire logic busMasterReqPin,
  // Processor side
  output logic clock_stop_request_n,
  output logic arbiter_disable,
  output logic [2:0] idleState
);
  // ==========================================
  // Input synchronisers
  logic irqS1_q, irqS2_q, bmS1_q, bmS2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      irqS1_q <= 1'b0;
      irqS2_q <= 1'b0;
      bmS1_q <= 1'b0;
      bmS2_q <= 1'b0;
    end else begin
      irqS1_q <= irqPin;
      irqS2_q <= irqS1_q;
      bmS1_q <= busMasterReqPin;
      bmS2_q <= bmS1_q;
    end
  end

  // ==========================================
  // Register file
  localparam int DW = `DUTY_WIDTH;
  logic [31:0] ctrl_q, ctrl_d, wake_q, wake_d, rdata_q, rdata_d;
  logic [2:0] readIdle;
  logic access, wr, rd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  assign access = apbReq.psel && apbReq.penable;
  assign wr = access && apbReq.pwrite;
  assign rd = access && !apbReq.pwrite;

  // Capability word: flush-only is 0 because full invalidate is offered
  // Manual flush size and stride ride in the upper bytes
  localparam logic [31:0] CAPS = (32'h1 << `CAP_WRITEBACK_INVALIDATE_SUPPORTED_POS)
    | (32'h1 << `CAP_C2_POS) | (32'h1 << `CAP_C3_POS)
    | (32'(`FLUSH_SIZE_KB) << `CAP_SIZE_POS)
    | (32'(`FLUSH_STEP_BYTES) << `CAP_STEP_POS);

  // Read mux; entry registers read as zero, their effect is the side effect
  logic [31:0] rdSetup;
  always_comb begin
    rdSetup = 32'h0000_0000;
    if (hit(apbReq.paddr, `OFS_THROTTLE_CONTROL))
      rdSetup = ctrl_q;
    else if (hit(apbReq.paddr, `OFS_WAKE_CONTROL))
      rdSetup = wake_q;
    else if (hit(apbReq.paddr, `OFS_IDLE_STATUS))
      rdSetup = {29'h0, idleState};
    else if (hit(apbReq.paddr, `OFS_CACHE_CAPS))
      rdSetup = CAPS;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    wake_d = wake_q;
    rdata_d = rdata_q;
    readIdle = 3'h0;
    if (wr && hit(apbReq.paddr, `OFS_THROTTLE_CONTROL))
      ctrl_d = apbReq.pwdata;
    if (wr && hit(apbReq.paddr, `OFS_WAKE_CONTROL))
      wake_d = apbReq.pwdata & 32'h0000_0003;
    // Captured in setup so the data stands for the whole access cycle
    if (apbReq.psel && !apbReq.penable)
      rdata_d = rdSetup;
    if (rd && hit(apbReq.paddr, `ADDR_LEVEL_TWO))
      readIdle = 3'b010;
    if (rd && hit(apbReq.paddr, `ADDR_LEVEL_THREE))
      readIdle = 3'b100;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `CONTROL_RESET;
      wake_q <= `WAKE_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      wake_q <= wake_d;
      rdata_q <= rdata_d;
    end
  end

  // Zero-wait slave; read data is registered from the setup cycle
  assign apbRsp.prdata = rdata_q;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = 1'b0;

  // ==========================================
  // Idle state machine
  cpu_throttle_pkg::idle_e idle_q, idle_d;
  logic bmWake;
  assign bmWake = wake_q[`WAKE_BM_POS] && bmS2_q;

  always_comb begin
    idle_d = idle_q;
    case (idle_q)
      cpu_throttle_pkg::RUN: begin
        if (readIdle == 3'b010)
          idle_d = cpu_throttle_pkg::IDLE_C2;
        else if (readIdle == 3'b100)
          idle_d = cpu_throttle_pkg::IDLE_C3;
      end
      cpu_throttle_pkg::IDLE_C2: begin
        // Snoops continue in C2, so no arbiter gating here
        if (irqS2_q || bmWake)
          idle_d = cpu_throttle_pkg::RUN;
      end
      cpu_throttle_pkg::IDLE_C3: begin
        if (irqS2_q || bmWake)
          idle_d = cpu_throttle_pkg::RUN;
      end
      default: idle_d = cpu_throttle_pkg::RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset)
      idle_q <= cpu_throttle_pkg::RUN;
    else
      idle_q <= idle_d;
  end

  // ==========================================
  // Throttle generator
  logic [DW-1:0] duty, slot_q, slot_d;
  logic [7:0] div_q, div_d;
  logic thEn, runSlot, stop_q, stop_d;
  assign duty = ctrl_q[`DUTY_POS +: DW];
  assign thEn = ctrl_q[`THROTTLE_EN_POS];

  // Duty zero is reserved; treated as unthrottled so the core never starves
  always_comb begin
    div_d = (div_q == 8'(`STOP_SLOT_CYC - 1)) ? 8'h00 : div_q + 8'h01;
    slot_d = slot_q;
    if (div_q == 8'(`STOP_SLOT_CYC - 1))
      slot_d = slot_q + 1'b1;
    if (!thEn) begin
      div_d = 8'h00;
      slot_d = '0;
    end
    runSlot = (duty == '0) || (slot_q < duty);
    // Stop request while idle halts execution; C0 alone runs
    stop_d = (idle_d != cpu_throttle_pkg::RUN)
      || (thEn && !runSlot);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= 8'h00;
      slot_q <= '0;
      stop_q <= 1'b0;
    end else begin
      div_q <= div_d;
      slot_q <= slot_d;
      stop_q <= stop_d;
    end
  end

  // One block per processor: replicate this module per core
  // C1 halt is internal to the core; nothing here
  assign clock_stop_request_n = !stop_q;
  assign arbiter_disable = wake_q[`ARBITER_DISABLE_POS]
    && (idle_q == cpu_throttle_pkg::IDLE_C3);
  assign idleState = idle_q;

  // ==========================================
  // Assertions
  idle_two_a: assert property (@(posedge clk) disable iff (reset)
    (rd && apbReq.paddr == `ADDR_LEVEL_TWO && idle_q == cpu_throttle_pkg::RUN)
    |=> idle_q == cpu_throttle_pkg::IDLE_C2)
    else $error("level two read did not enter C2");
  idle_three_a: assert property (@(posedge clk) disable iff (reset)
    (rd && apbReq.paddr == `ADDR_LEVEL_THREE
     && idle_q == cpu_throttle_pkg::RUN)
    |=> idle_q == cpu_throttle_pkg::IDLE_C3)
    else $error("level three read did not enter C3");
  c2_wake_a: assert property (@(posedge clk) disable iff (reset)
    (idle_q == cpu_throttle_pkg::IDLE_C2 && irqS2_q)
    |=> idle_q == cpu_throttle_pkg::RUN)
    else $error("interrupt did not end C2");
  bm_nowake_a: assert property (@(posedge clk) disable iff (reset)
    (idle_q != cpu_throttle_pkg::RUN && !irqS2_q && !wake_q[`WAKE_BM_POS])
    |=> idle_q == $past(idle_q))
    else $error("idle left without wake source");
  stop_release_a: assert property (@(posedge clk) disable iff (reset)
    (!thEn && idle_d == cpu_throttle_pkg::RUN)
    |=> clock_stop_request_n)
    else $error("stop request held with throttle off");
  idle_stops_a: assert property (@(posedge clk) disable iff (reset)
    (idle_q != cpu_throttle_pkg::RUN) |-> !clock_stop_request_n)
    else $error("clock running while idle");
  run_share_a: assert property (@(posedge clk) disable iff (reset)
    (thEn && duty != '0 && slot_q < duty && idle_d == cpu_throttle_pkg::RUN)
    |=> clock_stop_request_n)
    else $error("stop asserted inside run share");
  stop_share_a: assert property (@(posedge clk) disable iff (reset)
    (thEn && duty != '0 && slot_q >= duty) |=> !clock_stop_request_n)
    else $error("no stop in stop share");
  reset_ctrl_a: assert property (@(posedge clk)
    reset |=> ctrl_q == 32'h0000_0000)
    else $error("control not cleared by reset");
  caps_a: assert property (@(posedge clk) disable iff (reset)
    (rd && apbReq.paddr == `OFS_CACHE_CAPS)
    |-> apbRsp.prdata[`CAP_FLUSH_ONLY_POS] == 1'b0)
    else $error("flush-only flag set with full invalidate");
  c3_irq_a: assert property (@(posedge clk) disable iff (reset)
    (idle_q == cpu_throttle_pkg::IDLE_C3 && irqS2_q)
    |=> idle_q == cpu_throttle_pkg::RUN)
    else $error("interrupt did not end C3");
  bm_wake_a: assert property (@(posedge clk) disable iff (reset)
    (idle_q != cpu_throttle_pkg::RUN && bmS2_q && wake_q[`WAKE_BM_POS])
    |=> idle_q == cpu_throttle_pkg::RUN)
    else $error("bus request did not end idle");
  c2_snoop_a: assert property (@(posedge clk) disable iff (reset)
    (idle_q == cpu_throttle_pkg::IDLE_C2) |-> !arbiter_disable)
    else $error("arbiter gated in C2");
  arb_c3_a: assert property (@(posedge clk) disable iff (reset)
    arbiter_disable |-> idle_q == cpu_throttle_pkg::IDLE_C3)
    else $error("arbiter gated outside C3");
  run_reset_a: assert property (@(posedge clk)
    reset |=> idle_q == cpu_throttle_pkg::RUN && clock_stop_request_n)
    else $error("reset did not return to running");
  duty_zero_a: assert property (@(posedge clk) disable iff (reset)
    (thEn && duty == '0 && idle_d == cpu_throttle_pkg::RUN)
    |=> clock_stop_request_n)
    else $error("reserved duty stopped the clock");
  wr_ctrl_a: assert property (@(posedge clk) disable iff (reset)
    (wr && apbReq.paddr == `OFS_THROTTLE_CONTROL)
    |=> ctrl_q == $past(apbReq.pwdata))
    else $error("control write lost");
  slot_wrap_a: assert property (@(posedge clk) disable iff (reset)
    (thEn && div_q == 8'(`STOP_SLOT_CYC - 1)) |=> div_q == 8'h00)
    else $error("slot divider did not wrap");
  div_clear_a: assert property (@(posedge clk) disable iff (reset)
    !thEn |=> div_q == 8'h00 && slot_q == '0)
    else $error("throttle counters not cleared");
  // ==========================================
  // Covers
  c2_cov: cover property (@(posedge clk) idle_q == cpu_throttle_pkg::IDLE_C2);
  bm_cov: cover property (@(posedge clk) bmWake
    && idle_q == cpu_throttle_pkg::IDLE_C3);
  arb_cov: cover property (@(posedge clk) arbiter_disable);
  c3_cov: cover property (@(posedge clk) idle_q == cpu_throttle_pkg::IDLE_C3);
  thr_cov: cover property (@(posedge clk) thEn && !clock_stop_request_n);
endmodule

// file: design/cpu_throttle_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock logic
`ifndef CPU_THROTTLE_CFG_SVH
`define CPU_THROTTLE_CFG_SVH
`define OFS_THROTTLE_CONTROL 12'h000
`define OFS_LEVEL_TWO 12'h004
`define OFS_LEVEL_THREE 12'h005
`define OFS_WAKE_CONTROL 12'h008
`define OFS_IDLE_STATUS 12'h00C
`define OFS_CACHE_CAPS 12'h010
`define ADDR_LEVEL_TWO 12'h004
`define ADDR_LEVEL_THREE 12'h014
`define DUTY_POS 1
`define DUTY_WIDTH 3
`define THROTTLE_EN_POS 4
`define WAKE_BM_POS 0
`define ARBITER_DISABLE_POS 1
`define CAP_WRITEBACK_INVALIDATE_SUPPORTED_POS 0
`define CAP_FLUSH_ONLY_POS 1
`define CAP_C2_POS 2
`define CAP_C3_POS 3
`define CAP_STEP_POS 8
`define CAP_SIZE_POS 16
`define CONTROL_RESET 32'h0000_0000
`define WAKE_RESET 32'h0000_0000
`define FLUSH_LIMIT_KB 2048
`define FLUSH_STEP_BYTES 32
`define FLUSH_SIZE_KB 1024
`define CLK_MHZ 250
`define STOP_SLOT_NS 32
`define STOP_SLOT_CYC ((`STOP_SLOT_NS * `CLK_MHZ) / 1000)
`endif

// file: design/cpu_throttle_pkg.sv
// Types shared by the processor clock control logic
package cpu_throttle_pkg;
  typedef enum logic [2:0] {
    RUN = 3'b001,
    IDLE_C2 = 3'b010,
    IDLE_C3 = 3'b100
  } idle_e;
  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
endpackage

// file: tb/cpu_core_model.sv
// Behavioural processor core that runs only while its clock is not stopped
module cpu_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Count control
  input wire logic countClear,
  // Clock stop from the throttle logic
  input wire logic clock_stop_request_n,
  // Executed cycles
  output int runCycles
);
  // ==========================================
  // Core clock gate
  always_ff @(posedge clk) begin
    if (reset || countClear) begin
      runCycles <= 0;
    end else if (clock_stop_request_n) begin
      runCycles <= runCycles + 1;
    end
  end
endmodule

// file: tb/cpu_power_state_throttle_tb.sv
// Self-checking bench for the processor clock throttle and idle logic
`include "cpu_throttle_cfg.svh"
module cpu_power_state_throttle_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic irqPin = 1'b0;
  logic busMasterReqPin = 1'b0;
  logic countClear = 1'b0;
  cpu_throttle_pkg::apb_req_s apbReq = '0;
  cpu_throttle_pkg::apb_rsp_s apbRsp;
  logic clock_stop_request_n;
  logic arbiter_disable;
  logic [2:0] idleState;
  int runCycles;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] expQ[$];
  logic [31:0] ctl;
  int base;
  int d;
  initial begin
    forever #2 clk = ~clk;
  end
  cpu_power_state_throttle i_dut (.clk(clk), .reset(reset),
    .apbReq(apbReq), .apbRsp(apbRsp), .irqPin(irqPin),
    .busMasterReqPin(busMasterReqPin),
    .clock_stop_request_n(clock_stop_request_n),
    .arbiter_disable(arbiter_disable), .idleState(idleState));
  cpu_core_model i_core (.clk(clk), .reset(reset), .countClear(countClear),
    .clock_stop_request_n(clock_stop_request_n), .runCycles(runCycles));
  // ==========================================
  // Compare, verdict and watchdog
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #80000;
    num_errors++;
    summarize();
  end
  // ==========================================
  // Bus master; read results are noted for the monitor
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd, input logic [31:0] exp);
    if (!w) begin
      expQ.push_back(exp);
    end
    @(posedge clk);
    apbReq <= '{paddr: a, pwrite: w, pwdata: wd, psel: 1'b1, penable: 1'b0};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1
        && !apbReq.pwrite) begin
      check(apbRsp.prdata, expQ.pop_front());
      check({31'h0, apbRsp.pslverr}, 32'h0);
    end
  end
  // Sync stages need a few edges before the state settles
  task automatic expectState(input logic [2:0] st, input logic stopN);
    repeat (5) @(posedge clk);
    check({29'h0, idleState}, {29'h0, st});
    check({31'h0, clock_stop_request_n}, {31'h0, stopN});
  endtask
  // ==========================================
  // Scenarios
  initial begin
    base = $urandom(32'h110bec73);
    base = $urandom % 7;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    apb(`OFS_THROTTLE_CONTROL, 1'b0, 32'h0, 32'h0);
    expectState(cpu_throttle_pkg::RUN, 1'b1);
    for (int i = 0; i < 7; i++) begin
      d = ((base + i) % 7) + 1;
      ctl = 32'(d) << `DUTY_POS;
      apb(`OFS_THROTTLE_CONTROL, 1'b1, 32'h0, 32'h0);
      apb(`OFS_THROTTLE_CONTROL, 1'b1, ctl, 32'h0);
      ctl = ctl | (32'h1 << `THROTTLE_EN_POS);
      apb(`OFS_THROTTLE_CONTROL, 1'b1, ctl, 32'h0);
      apb(`OFS_THROTTLE_CONTROL, 1'b0, 32'h0, ctl);
      repeat (64) @(posedge clk);
      countClear <= 1'b1;
      @(posedge clk);
      countClear <= 1'b0;
      // Ten whole periods; one more edge as the last count lands after it
      repeat (641) @(posedge clk);
      check({31'h0, runCycles >= d * 80 && runCycles <= d * 80 + 8},
            32'h1);
    end
    apb(`OFS_THROTTLE_CONTROL, 1'b1, 32'h0, 32'h0);
    expectState(cpu_throttle_pkg::RUN, 1'b1);
    apb(`OFS_WAKE_CONTROL, 1'b1, 32'h0, 32'h0);
    apb(`ADDR_LEVEL_THREE, 1'b0, 32'h0, 32'h0);
    expectState(cpu_throttle_pkg::IDLE_C3, 1'b0);
    busMasterReqPin <= 1'b1;
    expectState(cpu_throttle_pkg::IDLE_C3, 1'b0);
    busMasterReqPin <= 1'b0;
    irqPin <= 1'b1;
    expectState(cpu_throttle_pkg::RUN, 1'b1);
    irqPin <= 1'b0;
    ctl = (32'h1 << `WAKE_BM_POS) | (32'h1 << `ARBITER_DISABLE_POS);
    apb(`OFS_WAKE_CONTROL, 1'b1, ctl, 32'h0);
    apb(`ADDR_LEVEL_THREE, 1'b0, 32'h0, 32'h0);
    expectState(cpu_throttle_pkg::IDLE_C3, 1'b0);
    check({31'h0, arbiter_disable}, 32'h1);
    busMasterReqPin <= 1'b1;
    expectState(cpu_throttle_pkg::RUN, 1'b1);
    busMasterReqPin <= 1'b0;
    apb(`ADDR_LEVEL_TWO, 1'b0, 32'h0, 32'h0);
    expectState(cpu_throttle_pkg::IDLE_C2, 1'b0);
    irqPin <= 1'b1;
    expectState(cpu_throttle_pkg::RUN, 1'b1);
    irqPin <= 1'b0;
    // Single core, so arbiter gating stands in for a flush
    apb(`OFS_IDLE_STATUS, 1'b0, 32'h0, 32'h1);
    ctl = (32'h1 << `CAP_WRITEBACK_INVALIDATE_SUPPORTED_POS) | (32'h1 << `CAP_C2_POS)
      | (32'h1 << `CAP_C3_POS) | (32'(`FLUSH_SIZE_KB) << `CAP_SIZE_POS)
      | (32'(`FLUSH_STEP_BYTES) << `CAP_STEP_POS);
    apb(`OFS_CACHE_CAPS, 1'b0, 32'h0, ctl);
    apb(12'h0F0, 1'b1, 32'hFFFF_FFFF, 32'h0);
    apb(12'h0F0, 1'b0, 32'h0, 32'h0);
    summarize();
  end
endmodule
